// ===== logic/tfrc_defs.svh
// Command codes, fields and reset values of the temperature fault block.
`ifndef TFRC_DEFS_SVH
`define TFRC_DEFS_SVH

`define TFRC_CMD_HOT_ACTION 8'h50
`define TFRC_CMD_HOT_WARN 8'h51
`define TFRC_CMD_COLD_WARN 8'h52
`define TFRC_CMD_COLD_FAULT 8'h53

`define TFRC_RESP_MSB 7
`define TFRC_RESP_LSB 6
`define TFRC_RETRY_MSB 5
`define TFRC_RETRY_LSB 3
`define TFRC_DELAY_MSB 2
`define TFRC_DELAY_LSB 0

`define TFRC_RETRY_NONE 3'h0
`define TFRC_RETRY_FOREVER 3'h7

`define TFRC_RST_HOT_ACTION 8'h00
`define TFRC_RST_HOT_WARN 16'h7BFF
`define TFRC_RST_COLD_WARN 16'h7C00
`define TFRC_RST_COLD_FAULT 16'h7C00
`define TFRC_UNMAPPED_DATA 16'h0000

`endif

// ===== logic/tfrc_pkg.sv
// Types shared by the temperature fault block and its command link.
package tfrc_pkg;

    // Command from the host: write or read of one command code.
    typedef struct packed {
        logic wr;
        logic [7:0] code;
        logic [15:0] data;
    } tfrc_req_t;

    // Answer to a command: hit is low for an unknown code.
    typedef struct packed {
        logic hit;
        logic [15:0] data;
    } tfrc_rsp_t;

    // Sticky status flags.
    typedef struct packed {
        logic cold_fault;
        logic cold_warn;
        logic hot_warn;
        logic hot_fault;
    } tfrc_flags_t;

    // Response field codes.
    typedef enum logic [1:0] {
        TFRC_RESP_IGNORE = 2'h0,
        TFRC_RESP_HOLD = 2'h1,
        TFRC_RESP_RETRY = 2'h2,
        TFRC_RESP_LATCH = 2'h3
    } tfrc_resp_t;

    // Fault sequencer states.
    typedef enum {
        TFRC_ST_RUN,
        TFRC_ST_HOLD,
        TFRC_ST_OFF,
        TFRC_ST_TRY,
        TFRC_ST_LATCH
    } tfrc_state_t;

endpackage

// ===== logic/tfrc_link.sv
// Link-clock end of the command port, with a toggle handshake to the core.
`timescale 1ns/1ps

module tfrc_link (
    input wire logic link_clk_i,
    input wire logic rst_n_i,
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input tfrc_pkg::tfrc_req_t cmd_i,
    output logic rsp_valid_o,
    output tfrc_pkg::tfrc_rsp_t rsp_o,
    output logic req_tgl_o,
    output tfrc_pkg::tfrc_req_t req_o,
    input wire logic ack_tgl_i,
    input tfrc_pkg::tfrc_rsp_t core_rsp_i
);

    logic rst_sync1_r;
    logic rst_sync2_r;
    logic pending_r;
    logic ack_sync1_r;
    logic ack_sync2_r;
    logic ack_seen_r;
    logic ack_evt;

    // Reset release is synchronised to the link clock.
    always_ff @(posedge link_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync1_r <= 1'b0;
            rst_sync2_r <= 1'b0;
        end else begin
            rst_sync1_r <= 1'b1;
            rst_sync2_r <= rst_sync1_r;
        end
    end

    // The core's acknowledge toggle passes two flip-flops.
    always_ff @(posedge link_clk_i or negedge rst_sync2_r) begin
        if (!rst_sync2_r) begin
            ack_sync1_r <= 1'b0;
            ack_sync2_r <= 1'b0;
            ack_seen_r <= 1'b0;
        end else begin
            ack_sync1_r <= ack_tgl_i;
            ack_sync2_r <= ack_sync1_r;
            ack_seen_r <= ack_sync2_r;
        end
    end

    assign ack_evt = ack_sync2_r ^ ack_seen_r;
    assign cmd_ready_o = ~pending_r;

    // One command at a time; the held word stays still until the core answers.
    always_ff @(posedge link_clk_i or negedge rst_sync2_r) begin
        if (!rst_sync2_r) begin
            pending_r <= 1'b0;
            req_tgl_o <= 1'b0;
            req_o <= '0;
        end else if (cmd_valid_i && !pending_r) begin
            pending_r <= 1'b1;
            req_tgl_o <= ~req_tgl_o;
            req_o <= cmd_i;
        end else if (ack_evt) begin
            pending_r <= 1'b0;
        end
    end

    // The answer word is stable when its toggle arrives, so it is taken whole.
    always_ff @(posedge link_clk_i or negedge rst_sync2_r) begin
        if (!rst_sync2_r) begin
            rsp_valid_o <= 1'b0;
            rsp_o <= '0;
        end else begin
            rsp_valid_o <= ack_evt;
            if (ack_evt) begin
                rsp_o <= core_rsp_i;
            end
        end
    end

endmodule

// ===== logic/tfrc_top.sv
// Temperature thresholds, fault flags and fault-response retry sequencer.
//
// Functional notes
// - Retry setting 101 makes exactly five restart attempts.
// - Retry setting 110 makes exactly six restart attempts.
// - When all attempts fail the output stays off until cleared.
// - Retry setting 111 retries until commanded off, bias loss or another fault.
// - Delay field bits 2:0 of value n give 2 to the n time units, 1 up to 128.
// - The delay is both the run-on time and the spacing of restart starts.
// - The time unit comes from the separate time_unit_i input port.
// - Command 0x51 holds the 16-bit Linear hot warning threshold.
// - Command 0x52 holds the 16-bit cold warning threshold.
// - Command 0x53 holds the 16-bit Linear cold fault threshold.
// - Response bits 7:6 select ignore, run on, shut down and retry, or latch off.
// - Retry setting zero makes no attempt and leaves the output off until cleared.
// - A latch clears on a bit clear, a clear-all, an off-then-on cycle or bias loss.
// - Retry settings 001 to 100 give one to four attempts before latching off.
`timescale 1ns/1ps
`include "tfrc_defs.svh"

module tfrc_top #(
    parameter int TIMER_W = 24
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic link_clk_i,
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input tfrc_pkg::tfrc_req_t cmd_i,
    output logic rsp_valid_o,
    output tfrc_pkg::tfrc_rsp_t rsp_o,
    input wire logic [15:0] temp_i,
    input wire logic temp_valid_i,
    input wire logic hot_fault_i,
    input wire logic other_fault_i,
    input wire logic [15:0] time_unit_i,
    input wire logic ctrl_on_i,
    input wire logic bias_ok_i,
    input wire logic clear_faults_i,
    input wire logic [3:0] flag_clear_i,
    output logic out_en_o,
    output logic latched_off_o,
    output logic [2:0] attempts_o,
    output tfrc_pkg::tfrc_flags_t flags_o
);

    logic rst_sync1_r;
    logic rst_sync2_r;
    logic rst_n;
    logic on_sync1_r;
    logic on_sync2_r;
    logic on_prev_r;
    logic bias_sync1_r;
    logic bias_sync2_r;
    logic bias_prev_r;
    logic run_en;
    logic on_rise;
    logic bias_fall;
    logic clear_all;
    logic req_tgl;
    tfrc_pkg::tfrc_req_t req;
    logic req_sync1_r;
    logic req_sync2_r;
    logic req_seen_r;
    logic req_evt;
    logic ack_tgl_r;
    tfrc_pkg::tfrc_rsp_t core_rsp_r;
    logic [7:0] hot_action_r;
    logic [15:0] hot_warn_thr_r;
    logic [15:0] cold_warn_thr_r;
    logic [15:0] cold_fault_thr_r;
    tfrc_pkg::tfrc_resp_t resp_mode;
    logic [2:0] retry_set;
    logic [2:0] delay_exp;
    logic [TIMER_W-1:0] unit_cyc;
    logic [TIMER_W-1:0] delay_cyc;
    logic [TIMER_W-1:0] timer_r;
    logic timer_done;
    logic [2:0] tries_r;
    logic more_tries;
    tfrc_pkg::tfrc_state_t state_r;
    logic [3:0] flag_set;
    logic [3:0] flag_r;

    // Linear value (5-bit exponent, 11-bit mantissa) to one signed fixed-point scale.
    function automatic logic signed [47:0] lin_fix(input logic [15:0] v);
        logic signed [47:0] y;
        logic [4:0] sh;
        y = {{37{v[10]}}, v[10:0]};
        sh = {~v[15], v[14:11]};
        lin_fix = y <<< sh;
    endfunction

    // Reset release through two flip-flops.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync1_r <= 1'b0;
            rst_sync2_r <= 1'b0;
        end else begin
            rst_sync1_r <= 1'b1;
            rst_sync2_r <= rst_sync1_r;
        end
    end

    assign rst_n = rst_sync2_r;

    // Control and bias pins are synchronised; edges come after the second stage.
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            on_sync1_r <= 1'b0;
            on_sync2_r <= 1'b0;
            on_prev_r <= 1'b0;
            bias_sync1_r <= 1'b0;
            bias_sync2_r <= 1'b0;
            bias_prev_r <= 1'b0;
        end else begin
            on_sync1_r <= ctrl_on_i;
            on_sync2_r <= on_sync1_r;
            on_prev_r <= on_sync2_r;
            bias_sync1_r <= bias_ok_i;
            bias_sync2_r <= bias_sync1_r;
            bias_prev_r <= bias_sync2_r;
        end
    end

    assign run_en = on_sync2_r & bias_sync2_r;
    assign on_rise = on_sync2_r & ~on_prev_r;
    assign bias_fall = ~bias_sync2_r & bias_prev_r;
    assign clear_all = clear_faults_i | on_rise | bias_fall;

    // Link-clock side of the command port.
    tfrc_link u_link (
        .link_clk_i(link_clk_i),
        .rst_n_i(rst_n_i),
        .cmd_valid_i(cmd_valid_i),
        .cmd_ready_o(cmd_ready_o),
        .cmd_i(cmd_i),
        .rsp_valid_o(rsp_valid_o),
        .rsp_o(rsp_o),
        .req_tgl_o(req_tgl),
        .req_o(req),
        .ack_tgl_i(ack_tgl_r),
        .core_rsp_i(core_rsp_r)
    );

    // The request toggle passes two flip-flops; the held word is stable by then.
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            req_sync1_r <= 1'b0;
            req_sync2_r <= 1'b0;
            req_seen_r <= 1'b0;
        end else begin
            req_sync1_r <= req_tgl;
            req_sync2_r <= req_sync1_r;
            req_seen_r <= req_sync2_r;
        end
    end

    assign req_evt = req_sync2_r ^ req_seen_r;

    // Threshold and response registers written by host commands.
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            hot_action_r <= `TFRC_RST_HOT_ACTION;
            hot_warn_thr_r <= `TFRC_RST_HOT_WARN;
            cold_warn_thr_r <= `TFRC_RST_COLD_WARN;
            cold_fault_thr_r <= `TFRC_RST_COLD_FAULT;
        end else if (req_evt && req.wr) begin
            case (req.code)
                `TFRC_CMD_HOT_ACTION: hot_action_r <= req.data[7:0];
                `TFRC_CMD_HOT_WARN: hot_warn_thr_r <= req.data;
                `TFRC_CMD_COLD_WARN: cold_warn_thr_r <= req.data;
                `TFRC_CMD_COLD_FAULT: cold_fault_thr_r <= req.data;
                default: begin
                end
            endcase
        end
    end

    // Answers each known command with the stored value, read before any write; other codes get hit low and zero data.
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ack_tgl_r <= 1'b0;
            core_rsp_r <= '0;
        end else if (req_evt) begin
            ack_tgl_r <= ~ack_tgl_r;
            core_rsp_r.hit <= 1'b1;
            case (req.code)
                `TFRC_CMD_HOT_ACTION: core_rsp_r.data <= {8'h00, hot_action_r};
                `TFRC_CMD_HOT_WARN: core_rsp_r.data <= hot_warn_thr_r;
                `TFRC_CMD_COLD_WARN: core_rsp_r.data <= cold_warn_thr_r;
                `TFRC_CMD_COLD_FAULT: core_rsp_r.data <= cold_fault_thr_r;
                default: begin
                    core_rsp_r.hit <= 1'b0;
                    core_rsp_r.data <= `TFRC_UNMAPPED_DATA;
                end
            endcase
        end
    end

    // Field decode of the response register.
    assign resp_mode = tfrc_pkg::tfrc_resp_t'(hot_action_r[`TFRC_RESP_MSB:`TFRC_RESP_LSB]);
    assign retry_set = hot_action_r[`TFRC_RETRY_MSB:`TFRC_RETRY_LSB];
    assign delay_exp = hot_action_r[`TFRC_DELAY_MSB:`TFRC_DELAY_LSB];

    // The time unit comes from outside; zero counts as one cycle.
    assign unit_cyc = (time_unit_i == 16'h0000) ? TIMER_W'(1) : TIMER_W'(time_unit_i);
    assign delay_cyc = unit_cyc << delay_exp;
    assign timer_done = (timer_r <= TIMER_W'(1));

    // More attempts until the count meets the setting; 111 never runs out.
    assign more_tries = (retry_set == `TFRC_RETRY_FOREVER) || (tries_r < retry_set);

    // Fault sequencer: run-on, shutdown, spaced restart attempts and latch-off.
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= tfrc_pkg::TFRC_ST_RUN;
            timer_r <= '0;
            tries_r <= 3'h0;
        end else if (!run_en) begin
            state_r <= tfrc_pkg::TFRC_ST_RUN;
            timer_r <= '0;
            tries_r <= 3'h0;
        end else if (other_fault_i) begin
            state_r <= tfrc_pkg::TFRC_ST_LATCH;
            tries_r <= 3'h0;
        end else if (state_r != tfrc_pkg::TFRC_ST_RUN && (clear_all || flag_clear_i[0])) begin
            state_r <= tfrc_pkg::TFRC_ST_RUN;
            timer_r <= '0;
            tries_r <= 3'h0;
        end else begin
            case (state_r)
                tfrc_pkg::TFRC_ST_RUN: begin
                    if (hot_fault_i) begin
                        case (resp_mode)
                            tfrc_pkg::TFRC_RESP_HOLD: begin
                                state_r <= tfrc_pkg::TFRC_ST_HOLD;
                                timer_r <= delay_cyc;
                            end
                            tfrc_pkg::TFRC_RESP_RETRY: begin
                                tries_r <= 3'h0;
                                timer_r <= delay_cyc;
                                if (retry_set == `TFRC_RETRY_NONE) begin
                                    state_r <= tfrc_pkg::TFRC_ST_LATCH;
                                end else begin
                                    state_r <= tfrc_pkg::TFRC_ST_OFF;
                                end
                            end
                            tfrc_pkg::TFRC_RESP_LATCH: state_r <= tfrc_pkg::TFRC_ST_LATCH;
                            default: begin
                            end
                        endcase
                    end
                end
                tfrc_pkg::TFRC_ST_HOLD: begin
                    if (!timer_done) begin
                        timer_r <= timer_r - TIMER_W'(1);
                    end else if (!hot_fault_i) begin
                        state_r <= tfrc_pkg::TFRC_ST_RUN;
                    end else if (retry_set == `TFRC_RETRY_NONE) begin
                        state_r <= tfrc_pkg::TFRC_ST_LATCH;
                    end else begin
                        state_r <= tfrc_pkg::TFRC_ST_OFF;
                        timer_r <= delay_cyc;
                        tries_r <= 3'h0;
                    end
                end
                tfrc_pkg::TFRC_ST_OFF: begin
                    if (!timer_done) begin
                        timer_r <= timer_r - TIMER_W'(1);
                    end else begin
                        state_r <= tfrc_pkg::TFRC_ST_TRY;
                        timer_r <= delay_cyc;
                        tries_r <= tries_r + 3'h1;
                    end
                end
                tfrc_pkg::TFRC_ST_TRY: begin
                    if (hot_fault_i) begin
                        if (more_tries) begin
                            state_r <= tfrc_pkg::TFRC_ST_OFF;
                            timer_r <= timer_done ? TIMER_W'(1) : timer_r - TIMER_W'(1);
                        end else begin
                            state_r <= tfrc_pkg::TFRC_ST_LATCH;
                        end
                    end else if (timer_done) begin
                        state_r <= tfrc_pkg::TFRC_ST_RUN;
                        tries_r <= 3'h0;
                    end else begin
                        timer_r <= timer_r - TIMER_W'(1);
                    end
                end
                tfrc_pkg::TFRC_ST_LATCH: begin
                    timer_r <= '0;
                end
                default: state_r <= tfrc_pkg::TFRC_ST_RUN;
            endcase
        end
    end

    // Outputs, one cycle behind the state.
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            out_en_o <= 1'b0;
            latched_off_o <= 1'b0;
            attempts_o <= 3'h0;
        end else begin
            out_en_o <= run_en && state_r != tfrc_pkg::TFRC_ST_OFF && state_r != tfrc_pkg::TFRC_ST_LATCH;
            latched_off_o <= (state_r == tfrc_pkg::TFRC_ST_LATCH);
            attempts_o <= tries_r;
        end
    end

    // Flag sets: bit 0 from the hot fault input, bits 1 to 3 from threshold comparisons on each new Linear temperature sample.
    always_comb begin
        flag_set[0] = hot_fault_i;
        flag_set[1] = temp_valid_i && (lin_fix(temp_i) > lin_fix(hot_warn_thr_r));
        flag_set[2] = temp_valid_i && (lin_fix(temp_i) < lin_fix(cold_warn_thr_r));
        flag_set[3] = temp_valid_i && (lin_fix(temp_i) < lin_fix(cold_fault_thr_r));
    end

    // Sticky flags; a set in the clearing cycle wins.
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_flag
            always_ff @(posedge core_clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    flag_r[gi] <= 1'b0;
                end else if (flag_set[gi]) begin
                    flag_r[gi] <= 1'b1;
                end else if (clear_all || flag_clear_i[gi]) begin
                    flag_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    assign flags_o = tfrc_pkg::tfrc_flags_t'(flag_r);

endmodule

// ===== sim/tfrc_chk.sv
// Port-level assertion checker for the temperature fault block.
`timescale 1ns/1ps

module tfrc_chk (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic link_clk_i,
    input wire logic cmd_valid_i,
    input wire logic cmd_ready_o,
    input wire logic rsp_valid_o,
    input wire logic hot_fault_i,
    input wire logic other_fault_i,
    input wire logic ctrl_on_i,
    input wire logic bias_ok_i,
    input wire logic clear_faults_i,
    input wire logic temp_valid_i,
    input wire logic [3:0] flag_clear_i,
    input wire logic out_en_o,
    input wire logic latched_off_o,
    input wire logic [2:0] attempts_o,
    input tfrc_pkg::tfrc_flags_t flags_o
);
    // Pins held past their synchronisers, and a held other fault.
    sequence s_ctrl_off;
        !ctrl_on_i [*5];
    endsequence
    sequence s_bias_off;
        !bias_ok_i [*6];
    endsequence
    sequence s_other_hit;
        (other_fault_i && ctrl_on_i && bias_ok_i && !clear_faults_i) [*6];
    endsequence

    // Output and latch relations in the core domain.
    a_latch_dark: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        latched_off_o |-> !out_en_o) else $error("output on while latched");
    a_ctrl_off: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        s_ctrl_off |-> !out_en_o) else $error("output on while off");
    a_bias_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        s_bias_off |-> !out_en_o && !latched_off_o) else $error("bias loss did not clear");
    a_other_latch: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        s_other_hit |-> ##[0:2] latched_off_o) else $error("other fault did not latch");
    a_clear_all: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        clear_faults_i && !temp_valid_i && !hot_fault_i && !other_fault_i
        |=> flags_o == 4'h0 ##1 !latched_off_o) else $error("clear all left state");
    a_flag_one: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        flag_clear_i[1] && !temp_valid_i |=> !flags_o.hot_warn) else $error("bit clear failed");
    a_warn_sticky: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        $fell(flags_o.hot_warn) |-> $past(clear_faults_i) || $past(flag_clear_i[1]))
        else $error("warning dropped");
    a_attempt_step: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        attempts_o != $past(attempts_o) |-> attempts_o == 3'h0 || attempts_o == $past(attempts_o) + 3'h1)
        else $error("attempt count jumped");

    // Command port handshake in the link domain.
    a_rsp_pulse: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        rsp_valid_o |=> !rsp_valid_o) else $error("answer pulse too long");
    a_ready_busy: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        cmd_valid_i && cmd_ready_o |=> !cmd_ready_o [*3]) else $error("ready while busy");
endmodule

// ===== sim/tfrc_host.sv
// Behavioural command host on the link side of the temperature fault block.
`timescale 1ns/1ps

module tfrc_host (
    input wire logic link_clk_i,
    input wire logic cmd_ready_i,
    input wire logic rsp_valid_i,
    input tfrc_pkg::tfrc_rsp_t rsp_i,
    output logic cmd_valid_o,
    output tfrc_pkg::tfrc_req_t cmd_o
);
    // Nothing is offered at time zero.
    initial begin
        cmd_valid_o = 1'b0;
        cmd_o = '0;
    end

    // Offers one command, holds it until taken, then takes the answer.
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data, input int gap,
        output tfrc_pkg::tfrc_rsp_t rsp, output logic ok);
        int n;
        n = 0;
        repeat (gap + 1) @(posedge link_clk_i);
        #2;
        cmd_valid_o = 1'b1;
        cmd_o = {wr, code, data};
        while (!cmd_ready_i && n < 60) begin
            @(posedge link_clk_i);
            #2;
            n++;
        end
        @(posedge link_clk_i);
        #2;
        // Released lines show the inverse so a stale copy cannot pass.
        cmd_valid_o = 1'b0;
        cmd_o = ~cmd_o;
        while (!rsp_valid_i && n < 60) begin
            @(posedge link_clk_i);
            #2;
            n++;
        end
        rsp = rsp_i;
        ok = n < 60;
    endtask
endmodule

// ===== sim/tb_top.sv
// Self-checking bench for the temperature fault block.
`timescale 1ns/1ps
`include "tfrc_defs.svh"

module tb_top;
    logic core_clk_i = 1'b0;
    logic link_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic cmd_valid_i, cmd_ready_o, rsp_valid_o, out_en_o, latched_off_o;
    logic temp_valid_i = 1'b0;
    logic hot_fault_i = 1'b0;
    logic other_fault_i = 1'b0;
    logic ctrl_on_i = 1'b1;
    logic bias_ok_i = 1'b1;
    logic clear_faults_i = 1'b0;
    logic [3:0] flag_clear_i = 4'h0;
    logic [15:0] temp_i = 16'h0000;
    logic [15:0] time_unit_i = 16'h0002;
    logic [2:0] attempts_o;
    tfrc_pkg::tfrc_req_t cmd_i;
    tfrc_pkg::tfrc_rsp_t rsp_o;
    tfrc_pkg::tfrc_flags_t flags_o;
    int err_count = 0;
    int total_checks = 0;
    int cnt;
    // Rows: action byte, attempts, latch.
    logic [11:0] rows [10] = '{12'h821, 12'h8A3, 12'h925, 12'h9A7, 12'hA29, 12'hAAB, 12'hB2D,
        12'hCA1, 12'h525, 12'h120};
    // Rows: Linear temperature, expected flags.
    logic [19:0] temps [8] = '{20'h00500, 20'h00512, 20'hF8A00, 20'hF8A12, 20'h00140, 20'h00134,
        20'h000A4, 20'h0009C};

    // Clocks: core at 50 ns, link at 32 ns.
    always #25 core_clk_i = ~core_clk_i;
    always #16 link_clk_i = ~link_clk_i;

    tfrc_top i_tfrc_top (.*);

    tfrc_host i_tfrc_host (.link_clk_i, .cmd_ready_i(cmd_ready_o), .rsp_valid_i(rsp_valid_o),
        .rsp_i(rsp_o), .cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i));

    // Prints the counts and the verdict, then stops.
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Compares a seen value with the expected one.
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    // A wait that ran out ends the run.
    task automatic give_up(input string what);
        err_count++;
        $display("MISMATCH t=%0t %s timed out", $time, what);
        end_sim();
    endtask

    // Steps n core cycles and lands just after the edge.
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
        #2;
    endtask

    // One register command; a read compares hit and data.
    task automatic reg_io(input logic wr, input logic [7:0] code, input logic [15:0] data, input int gap,
        input logic [16:0] exp);
        tfrc_pkg::tfrc_rsp_t r;
        logic ok;
        i_tfrc_host.xfer(wr, code, data, gap, r, ok);
        if (!ok) give_up("command");
        if (!wr) check(r, exp, "read");
    endtask

    // Waits for the latch, or for a given attempt count.
    task automatic wait_for(input logic lat, input logic [2:0] att);
        int n;
        n = 0;
        while ((lat ? latched_off_o !== 1'b1 : attempts_o !== att) && n < 3000) begin
            cyc(1);
            n++;
        end
        if (n == 3000) give_up("sequencer");
    endtask

    // Clears flags and latch once the fault inputs settle.
    task automatic pulse_clear();
        cyc(2);
        clear_faults_i = 1'b1;
        cyc(1);
        clear_faults_i = 1'b0;
        cyc(4);
    endtask

    // Main sequence.
    initial begin
        repeat (16) @(posedge core_clk_i);
        #2;
        rst_n_i = 1'b1;
        cyc(8);
        reg_io(1'b0, `TFRC_CMD_HOT_ACTION, 16'h0000, 0, {1'b1, 8'h00, `TFRC_RST_HOT_ACTION});
        reg_io(1'b0, `TFRC_CMD_HOT_WARN, 16'h0000, 0, {1'b1, `TFRC_RST_HOT_WARN});
        reg_io(1'b0, `TFRC_CMD_COLD_WARN, 16'h0000, 2, {1'b1, `TFRC_RST_COLD_WARN});
        reg_io(1'b0, `TFRC_CMD_COLD_FAULT, 16'h0000, 0, {1'b1, `TFRC_RST_COLD_FAULT});
        reg_io(1'b0, 8'h60, 16'h0000, 0, 17'h00000);
        reg_io(1'b1, `TFRC_CMD_HOT_ACTION, 16'hABC2, 0, 17'h0);
        reg_io(1'b0, `TFRC_CMD_HOT_ACTION, 16'h0000, 0, 17'h100C2);
        $display("Register test done");
        foreach (rows[i]) begin
            pulse_clear();
            reg_io(1'b1, `TFRC_CMD_HOT_ACTION, {8'h00, rows[i][11:4]}, 0, 17'h0);
            check(out_en_o, 1'b1, "enabled");
            hot_fault_i = 1'b1;
            if (rows[i][0]) wait_for(1'b1, 3'h0);
            cyc(rows[i][0] ? 20 : 300);
            check(attempts_o, rows[i][3:1], "attempts");
            check(latched_off_o, rows[i][0], "latched");
            check(out_en_o, !rows[i][0], "output");
            hot_fault_i = 1'b0;
            $display("Sequencer row %0d done", i);
        end
        time_unit_i = 16'h0003;
        for (int n = 0; n < 8; n++) begin
            pulse_clear();
            reg_io(1'b1, `TFRC_CMD_HOT_ACTION, 16'h0090 + n, 3, 17'h0);
            hot_fault_i = 1'b1;
            wait_for(1'b0, 3'h1);
            cnt = 0;
            while (attempts_o !== 3'h2 && cnt < 1000) begin
                cyc(1);
                cnt++;
            end
            check(cnt, 3 << n, "spacing");
            hot_fault_i = 1'b0;
        end
        $display("Delay test done");
        pulse_clear();
        reg_io(1'b1, `TFRC_CMD_HOT_ACTION, 16'h00B8, 0, 17'h0);
        hot_fault_i = 1'b1;
        cyc(200);
        check(latched_off_o, 1'b0, "endless");
        ctrl_on_i = 1'b0;
        cyc(8);
        check(out_en_o, 1'b0, "off");
        ctrl_on_i = 1'b1;
        cyc(20);
        other_fault_i = 1'b1;
        cyc(8);
        check(latched_off_o, 1'b1, "other");
        other_fault_i = 1'b0;
        hot_fault_i = 1'b0;
        $display("Endless retry test done");
        for (int k = 0; k < 3; k++) begin
            pulse_clear();
            reg_io(1'b1, `TFRC_CMD_HOT_ACTION, 16'h00C0, 0, 17'h0);
            hot_fault_i = 1'b1;
            wait_for(1'b1, 3'h0);
            hot_fault_i = 1'b0;
            cyc(8);
            flag_clear_i = (k == 0) ? 4'h1 : 4'h0;
            ctrl_on_i = k != 1;
            bias_ok_i = k != 2;
            cyc(8);
            flag_clear_i = 4'h0;
            ctrl_on_i = 1'b1;
            bias_ok_i = 1'b1;
            cyc(8);
            check(latched_off_o, 1'b0, "cleared");
            check(out_en_o, 1'b1, "back");
        end
        $display("Clearing test done");
        reg_io(1'b1, `TFRC_CMD_HOT_WARN, 16'h0050, 0, 17'h0);
        reg_io(1'b1, `TFRC_CMD_COLD_WARN, 16'h0014, 0, 17'h0);
        reg_io(1'b1, `TFRC_CMD_COLD_FAULT, 16'h000A, 0, 17'h0);
        reg_io(1'b0, `TFRC_CMD_HOT_WARN, 16'h0000, 0, 17'h10050);
        reg_io(1'b0, `TFRC_CMD_COLD_WARN, 16'h0000, 0, 17'h10014);
        reg_io(1'b0, `TFRC_CMD_COLD_FAULT, 16'h0000, 0, 17'h1000A);
        foreach (temps[i]) begin
            pulse_clear();
            temp_i = temps[i][19:4];
            temp_valid_i = 1'b1;
            cyc(1);
            temp_valid_i = 1'b0;
            cyc(1);
            check(flags_o, temps[i][3:0], "flags");
            flag_clear_i = temps[i][3:0];
            cyc(2);
            flag_clear_i = 4'h0;
            check(flags_o, 4'h0, "bit clear");
        end
        $display("Threshold test done");
        end_sim();
    end
endmodule

bind tfrc_top tfrc_chk i_tfrc_chk (.*);
